// ==== ext_reset_model.sv ====
// External parts that are reset through the watchdog's reset-output pin
`timescale 1ns/1ps
module ext_reset_model (
	// Clock
	input wire logic clk_in,
	// Push-pull reset pin, so no released level to model
	input wire logic pin_n_in,
	// Resets seen
	output logic [15:0] pulses_out
);
	logic last_r = 1'b0;
	initial pulses_out = 16'h0000;
	always @(posedge clk_in) begin
		last_r <= pin_n_in;
		if (last_r && !pin_n_in) begin
			pulses_out <= pulses_out + 16'h0001;
		end
	end
endmodule

// ==== watchdog_reset_timer.sv ====
// Watchdog reset timer: 16-bit counter, prescaler, reload and reset output
// -----------------------------------------------------------------------
// How it works
// R1: Counter runs from every chip reset; no software start needed.
// R2: Disable request honoured only before end-of-init instruction.
// R3: Software must service the watchdog before it overflows.
// R4: Overflow raises an internal hardware reset pulse.
// R5: Overflow drives the reset-output pin low for external parts.
// R6: The watchdog counter is sixteen bits wide.
// R7: Counter advances every 2 or every 128 system clocks.
// R8: A programmable reload value feeds the counter's upper byte.
// R9: Servicing reloads upper byte from reload value, low byte cleared.
// R10: Prescaler and reload give intervals 25 us to 420 ms at 20 MHz.
// R11: Default timeout after reset is 65536 x 2 clocks, 6.55 ms.
// R12: End-of-init releases the reset pin high and closes disable window.
// R13: Counter counts up; overflow is the wrap from all-ones to zero.
// R14: Reset selects divide-by-2 and reload value zero.
// -----------------------------------------------------------------------
`timescale 1ns/1ps
module watchdog_reset_timer
	import wdt_pkg::*;
#(
	parameter int COUNT_WIDTH = WDT_WIDTH,
	parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Commands from the instruction decoder
	input wire wdt_cmd_t cmd_in,
	// Resets
	output logic wdt_reset_out,
	output logic reset_out_pin_n_out,
	// Status
	output wdt_status_t status_out
);

	// -----------------------------------------------------------------------
	// State
	// -----------------------------------------------------------------------
	wdt_state_t state_r;
	wdt_state_t state_nxt;
	logic [COUNT_WIDTH-1:0] count_r;
	logic [COUNT_WIDTH-1:0] count_nxt;
	logic [RELOAD_WIDTH-1:0] reload_r;
	logic presc_slow_r;
	logic init_done_r;
	logic pin_n_r;

	wire logic tick;
	wire logic running;
	wire logic overflow;
	wire logic disable_ok;
	wire logic pulse_active;
	wire logic [COUNT_WIDTH-1:0] reload_word;

	assign running = (state_r == WDT_RUNNING);
	assign overflow = running && tick && (&count_r); // [R13]
	assign disable_ok = cmd_in.disable_req && !init_done_r; // [R2]
	// Low byte restarts from zero; only the upper byte is programmable
	assign reload_word = {reload_r, {(COUNT_WIDTH-RELOAD_WIDTH){1'b0}}}; // [R8]

	// -----------------------------------------------------------------------
	// Sub-blocks
	// -----------------------------------------------------------------------
	wdt_prescaler #(
		.DIV_WIDTH(PRESC_WIDTH)
	) u_presc (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.run_in(running),
		.slow_in(presc_slow_r),
		.restart_in(cmd_in.service),
		.tick_out(tick)
	);

	wdt_pulse #(
		.PULSE_CYCLES(PULSE_CYCLES)
	) u_pulse (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.trigger_in(overflow),
		.active_out(pulse_active)
	);

	// -----------------------------------------------------------------------
	// Next state and counter
	// -----------------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		case (state_r)
			WDT_RUNNING: begin
				if (overflow) begin
					state_nxt = WDT_RESETTING; // [R4]
					count_nxt = COUNT_RESET;
				end else if (disable_ok) begin
					state_nxt = WDT_DISABLED; // [R2]
				end else if (cmd_in.service) begin
					count_nxt = reload_word; // [R9]
				end else if (tick) begin
					count_nxt = count_r + 1'b1; // [R6] [R13]
				end
			end
			WDT_DISABLED: begin
				if (cmd_in.service) begin
					count_nxt = reload_word;
				end
			end
			WDT_RESETTING: begin
				// Internal reset holds the block at defaults during the pulse; counting restarts once it is over
				if (!pulse_active) begin
					state_nxt = WDT_RUNNING;
				end
			end
			default: begin
				state_nxt = WDT_RUNNING;
			end
		endcase
	end

	// -----------------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r <= WDT_RUNNING; // [R1]
			count_r <= COUNT_RESET; // [R11]
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
		end
	end

	// Configuration; the watchdog reset returns it to defaults like a chip reset
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			reload_r <= RELOAD_RESET; // [R14]
			presc_slow_r <= PRESC_SEL_RESET; // [R14]
		end else if (state_r == WDT_RESETTING) begin
			reload_r <= RELOAD_RESET;
			presc_slow_r <= PRESC_SEL_RESET;
		end else begin
			if (cmd_in.reload_write) begin
				reload_r <= cmd_in.reload_data; // [R8] [R10]
			end
			if (cmd_in.presc_write) begin
				presc_slow_r <= cmd_in.presc_slow; // [R7] [R10]
			end
		end
	end

	// End-of-init is one-shot until the next reset of any kind
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			init_done_r <= 1'b0;
		end else if (overflow || state_r == WDT_RESETTING) begin
			init_done_r <= 1'b0;
		end else if (cmd_in.end_of_init) begin
			init_done_r <= 1'b1; // [R12]
		end
	end

	// Pin low from reset until end-of-init, and again on overflow
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pin_n_r <= 1'b0;
		end else if (overflow || state_r == WDT_RESETTING) begin
			pin_n_r <= 1'b0; // [R5]
		end else if (cmd_in.end_of_init) begin
			pin_n_r <= 1'b1; // [R12]
		end
	end

	// -----------------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------------
	assign wdt_reset_out = pulse_active; // [R4]
	assign reset_out_pin_n_out = pin_n_r;
	assign status_out.count = count_r;
	assign status_out.enabled = (state_r != WDT_DISABLED);
	assign status_out.init_done = init_done_r;
	assign status_out.presc_slow = presc_slow_r;
	assign status_out.reload_value = reload_r;

endmodule

// ==== watchdog_reset_timer_bench.sv ====
// Self-checking testbench for the watchdog reset timer
`timescale 1ns/1ps
module watchdog_reset_timer_bench;
	import wdt_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	wdt_cmd_t cmd_in = '0;
	wdt_cmd_t c;
	logic wdt_reset_out;
	logic pin_n;
	wdt_status_t st;
	logic [15:0] ext_cnt;
	logic [15:0] c0;
	int err_total = 0;
	int n_checks = 0;
	int n;
	always #5 clk_in = ~clk_in;
	watchdog_reset_timer dut (.clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd_in),
		.wdt_reset_out(wdt_reset_out), .reset_out_pin_n_out(pin_n), .status_out(st));
	ext_reset_model ext (.clk_in(clk_in), .pin_n_in(pin_n), .pulses_out(ext_cnt));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic send(input wdt_cmd_t k);
		@(posedge clk_in);
		cmd_in <= k;
		@(posedge clk_in);
		cmd_in <= '0;
		#1;
	endtask
	task automatic pause(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	task automatic do_reset;
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		pause(1);
	endtask
	task automatic t_defaults;
		check({st.enabled, st.presc_slow, st.reload_value, pin_n, wdt_reset_out}, 12'h800);
		c0 = st.count;
		pause(256);
		check(st.count - c0, 32'h80);
	endtask
	task automatic t_overflow;
		c = '0;
		c.reload_write = 1'b1;
		c.reload_data = 8'hff;
		send(c);
		check(st.reload_value, 8'hff);
		c = '0;
		c.service = 1'b1;
		send(c);
		check(st.count, 16'hff00);
		c = '0;
		c.end_of_init = 1'b1;
		send(c);
		check({pin_n, st.init_done}, 2'h3);
		c = '0;
		c.disable_req = 1'b1;
		send(c);
		check(st.enabled, 1'b1);
		c0 = ext_cnt;
		for (n = 6; n < 600 && wdt_reset_out !== 1'b1; n++) pause(1);
		// Roughly 256 ticks of two clocks after the service
		check(n >= 500 && n <= 520, 1'b1);
		check({pin_n, st.count}, 17'h00000);
		for (n = 0; n < 20 && wdt_reset_out === 1'b1; n++) pause(1);
		check(n, 4);
		check(ext_cnt - c0, 16'h0001);
		check({st.enabled, st.init_done, st.presc_slow, st.reload_value}, 11'h400);
	endtask
	task automatic t_slow;
		c = '0;
		c.presc_write = 1'b1;
		c.presc_slow = 1'b1;
		send(c);
		check(st.presc_slow, 1'b1);
		c0 = st.count;
		pause(256);
		check(st.count - c0, 32'h2);
		c = '0;
		c.service = 1'b1;
		send(c);
		check(wdt_reset_out, 1'b0);
	endtask
	task automatic t_disable;
		do_reset();
		c = '0;
		c.disable_req = 1'b1;
		send(c);
		check(st.enabled, 1'b0);
		c0 = st.count;
		pause(20);
		check(st.count, c0);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		do_reset();
		t_defaults();
		t_overflow();
		t_slow();
		t_disable();
		give_verdict();
	end
	// Tests need about 1100 cycles
	initial begin
		repeat (5000) @(posedge clk_in);
		err_total++;
		give_verdict();
	end
endmodule

// ==== watchdog_reset_timer_props.sv ====
// Checker for the watchdog reset timer ports
`timescale 1ns/1ps
module watchdog_reset_timer_props
	import wdt_pkg::*;
#(
	parameter int COUNT_WIDTH = WDT_WIDTH,
	parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Observed ports
	input wire wdt_cmd_t cmd_in,
	input wire logic wdt_reset_out,
	input wire logic reset_out_pin_n_out,
	input wire wdt_status_t status_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Overflow excluded: a tick at all-ones may coincide with a command
	wire quiet = !wdt_reset_out && status_out.count != 16'hffff;
	a_count_single_step: assert property (
		quiet && status_out.enabled && !cmd_in.service
		|=> (status_out.count - $past(status_out.count)) <= 16'h0001)
		else $error("count jumped");
	a_overflow_from_max: assert property ($rose(wdt_reset_out)
		|-> $past(status_out.count) == 16'hffff && status_out.count == 16'h0000)
		else $error("reset not caused by wrap");
	a_pulse_four_long: assert property ($rose(wdt_reset_out)
		|-> wdt_reset_out[*4] ##1 !wdt_reset_out)
		else $error("reset pulse length wrong");
	a_pin_low_reset: assert property (wdt_reset_out |-> !reset_out_pin_n_out)
		else $error("pin high during reset");
	a_service_load: assert property (
		quiet && cmd_in.service && !cmd_in.disable_req && !cmd_in.reload_write
		|=> status_out.count == {$past(status_out.reload_value), 8'h00})
		else $error("service load wrong");
	a_reload_store: assert property (quiet && cmd_in.reload_write
		|=> status_out.reload_value == $past(cmd_in.reload_data))
		else $error("reload value not stored");
	a_disable_locked: assert property (status_out.init_done && status_out.enabled
		|=> status_out.enabled)
		else $error("disabled after end of init");
	a_init_pin_high: assert property (quiet && cmd_in.end_of_init
		|=> reset_out_pin_n_out && status_out.init_done)
		else $error("end of init not shown");
	a_restart_defaults: assert property ($fell(wdt_reset_out)
		|-> status_out.enabled && !status_out.presc_slow && status_out.reload_value == 8'h00)
		else $error("defaults missing after overflow");
	c_overflow: cover property ($rose(wdt_reset_out));
	c_service: cover property (cmd_in.service);
	c_locked_disable: cover property (cmd_in.disable_req && status_out.init_done);
endmodule
bind watchdog_reset_timer watchdog_reset_timer_props #(.COUNT_WIDTH(COUNT_WIDTH),
	.PULSE_CYCLES(PULSE_CYCLES)) props (.clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd_in),
	.wdt_reset_out(wdt_reset_out), .reset_out_pin_n_out(reset_out_pin_n_out),
	.status_out(status_out));

// ==== wdt_pkg.sv ====
// Package with constants and types for the watchdog reset timer
package wdt_pkg;

	localparam int WDT_WIDTH = 16;
	localparam int RELOAD_WIDTH = 8;
	localparam int SLOW_DIV = 128;
	localparam int FAST_DIV = 2;
	localparam int PRESC_WIDTH = 7;
	localparam logic [RELOAD_WIDTH-1:0] RELOAD_RESET = 8'h00;
	localparam logic PRESC_SEL_RESET = 1'b0;
	localparam logic [WDT_WIDTH-1:0] COUNT_RESET = 16'h0000;
	// Reset pulse held on the internal reset, in clock cycles
	localparam int RESET_PULSE_CYCLES = 4;
	localparam int PULSE_CNT_WIDTH = 3;

	typedef enum logic [1:0] {
		WDT_RUNNING,
		WDT_DISABLED,
		WDT_RESETTING
	} wdt_state_t;

	// Commands from the instruction decoder
	typedef struct packed {
		logic service;
		logic disable_req;
		logic end_of_init;
		logic reload_write;
		logic [RELOAD_WIDTH-1:0] reload_data;
		logic presc_write;
		logic presc_slow;
	} wdt_cmd_t;

	// Observable status
	typedef struct packed {
		logic [WDT_WIDTH-1:0] count;
		logic enabled;
		logic init_done;
		logic presc_slow;
		logic [RELOAD_WIDTH-1:0] reload_value;
	} wdt_status_t;

endpackage

// ==== wdt_prescaler.sv ====
// Prescaler that gives a one-cycle tick every 2 or 128 system clocks
`timescale 1ns/1ps
module wdt_prescaler
	import wdt_pkg::*;
#(
	parameter int DIV_WIDTH = PRESC_WIDTH
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Control
	input wire logic run_in,
	input wire logic slow_in,
	input wire logic restart_in,
	// Tick
	output logic tick_out
);

	logic [DIV_WIDTH-1:0] div_r;
	logic [DIV_WIDTH-1:0] div_nxt;
	wire logic fast_tick;
	wire logic slow_tick;

	assign fast_tick = div_r[0];
	assign slow_tick = &div_r;
	assign tick_out = run_in && (slow_in ? slow_tick : fast_tick); // [R7]
	assign div_nxt = (restart_in || !run_in) ? '0 : div_r + 1'b1;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			div_r <= '0;
		end else begin
			div_r <= div_nxt;
		end
	end

endmodule

// ==== wdt_pulse.sv ====
// Stretches an overflow event into a fixed-length reset pulse
`timescale 1ns/1ps
module wdt_pulse
	import wdt_pkg::*;
#(
	parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Trigger and pulse
	input wire logic trigger_in,
	output logic active_out
);

	logic [PULSE_CNT_WIDTH-1:0] cnt_r;

	assign active_out = (cnt_r != '0);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_r <= '0;
		end else if (trigger_in) begin
			cnt_r <= PULSE_CNT_WIDTH'(PULSE_CYCLES);
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

endmodule
